// file: design/stcw_top.v
`timescale 1ns/10ps
`include "stcw_consts.vh"
module stcw_top (
    // clock and reset
    input  wire                       mclk_i,
    input  wire                       reset_n_i,
    // serial control pins
    input  wire                       sclk_i,
    input  wire                       sdata_i,
    input  wire                       strobe_i,
    input  wire                       transmit_gate_i,
    // decoded controls
    output wire [`STCW_ATT_W-1:0]     attenuation_code_o,
    output reg  [`STCW_ATT_DB_W-1:0]  atten_tenth_db_o,
    output wire                       divide_select_high_o,
    output wire                       divide_select_low_o,
    output reg  [`STCW_RATIO_W-1:0]   divide_ratio_o,
    output wire                       driver_mode_o,
    output wire                       offset_synth_enable_o,
    output wire                       lo_buffer_sleep_o,
    output wire                       refclk_buffer_sleep_o,
    output wire                       synth_active_o,
    output wire                       vga_enable_o
);
    ////////////////////////////////////////////////////////////////////////
    wire sclk_s;
    wire sdata_s;
    wire strobe_s;
    wire gate_s;

    stcw_sync u_sync_clk (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .async_i   (sclk_i),
        .sync_o    (sclk_s)
    );
    stcw_sync u_sync_dat (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .async_i   (sdata_i),
        .sync_o    (sdata_s)
    );
    stcw_sync u_sync_stb (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .async_i   (strobe_i),
        .sync_o    (strobe_s)
    );
    stcw_sync u_sync_txg (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .async_i   (transmit_gate_i),
        .sync_o    (gate_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // edge detection on synced pins
    reg sclk_d_ff;
    reg strobe_d_ff;
    reg gate_d_ff;
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            sclk_d_ff   <= 1'b0;
            strobe_d_ff <= 1'b0;
            gate_d_ff   <= 1'b0;
        end else begin
            sclk_d_ff   <= sclk_s;
            strobe_d_ff <= strobe_s;
            gate_d_ff   <= gate_s;
        end
    end
    wire sclk_rise   = sclk_s & ~sclk_d_ff;
    wire strobe_fall = ~strobe_s & strobe_d_ff;
    wire gate_fall   = ~gate_s & gate_d_ff;

    ////////////////////////////////////////////////////////////////////////
    // holding shift register, msb first
    reg  [`STCW_WORD_W-1:0] hold_ff;
    wire [`STCW_WORD_W-1:0] nxt_hold = {hold_ff[`STCW_WORD_W-2:0], sdata_s};
    always @(posedge mclk_i) begin
        if (!reset_n_i)
            hold_ff <= {`STCW_WORD_W{1'b0}};
        else if (sclk_rise)
            hold_ff <= nxt_hold;
    end

    ////////////////////////////////////////////////////////////////////////
    // bits seen since last strobe, saturating; blocks loads of partial words
    reg [`STCW_CNT_W-1:0] bit_cnt_ff;
    reg [`STCW_CNT_W-1:0] nxt_bit_cnt;
    always @* begin
        nxt_bit_cnt = bit_cnt_ff;
        if (strobe_fall)
            nxt_bit_cnt = {`STCW_CNT_W{1'b0}};
        else if (sclk_rise && (bit_cnt_ff != `STCW_BITS_FULL))
            nxt_bit_cnt = bit_cnt_ff + `STCW_CNT_ONE;
    end
    always @(posedge mclk_i) begin
        if (!reset_n_i)
            bit_cnt_ff <= {`STCW_CNT_W{1'b0}};
        else
            bit_cnt_ff <= nxt_bit_cnt;
    end
    wire word_full = (bit_cnt_ff == `STCW_BITS_FULL);

    wire addr_hit = (hold_ff[`STCW_ADDR_HI:`STCW_ADDR_LO] == `STCW_ADDR_VAL) &&
                    (hold_ff[`STCW_TAIL_HI:`STCW_TAIL_LO] == `STCW_TAIL_VAL);

    ////////////////////////////////////////////////////////////////////////
    // one transfer per strobe pulse
    reg                     loaded_ff;
    reg [`STCW_WORD_W-1:0]  work_ff;
    wire load = strobe_s & addr_hit & word_full & ~loaded_ff;
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            loaded_ff <= 1'b0;
            work_ff   <= {`STCW_WORD_W{1'b0}};
        end else begin
            if (!strobe_s)
                loaded_ff <= 1'b0;
            else if (load)
                loaded_ff <= 1'b1;
            if (load)
                work_ff <= hold_ff;
        end
    end

    assign attenuation_code_o    = work_ff[`STCW_ATT_HI:`STCW_ATT_LO];
    assign divide_select_high_o  = work_ff[`STCW_DIV_HI];
    assign divide_select_low_o   = work_ff[`STCW_DIV_LO];
    assign driver_mode_o         = work_ff[`STCW_MODE_BIT];
    assign offset_synth_enable_o = work_ff[`STCW_SE_BIT];
    assign lo_buffer_sleep_o     = work_ff[`STCW_SM1_BIT];
    assign refclk_buffer_sleep_o = work_ff[`STCW_SM2_BIT];

    ////////////////////////////////////////////////////////////////////////
    // attenuation code to tenths of a dB, codes above max clamp at -40 dB
    reg [`STCW_ATT_W-1:0]    att_clamp;
    reg [`STCW_ATT_W-1:0]    coarse_n;
    reg [`STCW_ATT_DB_W-1:0] nxt_att_db;
    always @* begin
        att_clamp = (attenuation_code_o > `STCW_ATT_MAX) ? `STCW_ATT_MAX : attenuation_code_o;
        coarse_n  = {`STCW_ATT_W{1'b0}};
        if (att_clamp <= `STCW_FINE_STEPS) begin
            nxt_att_db = `STCW_FINE_DB * {2'h0, att_clamp};
        end else begin
            coarse_n   = att_clamp - `STCW_FINE_STEPS;
            nxt_att_db = `STCW_FINE_SPAN_DB + `STCW_COARSE_DB * {2'h0, coarse_n};
        end
    end

    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            atten_tenth_db_o <= {`STCW_ATT_DB_W{1'b0}};
            divide_ratio_o   <= `STCW_RATIO_BASE;
        end else begin
            atten_tenth_db_o <= nxt_att_db;
            divide_ratio_o   <= `STCW_RATIO_BASE + {2'h0, work_ff[`STCW_DIV_HI:`STCW_DIV_LO]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // synthesizer-active latch, strobe set wins over gate clear
    reg synth_active_ff;
    always @(posedge mclk_i) begin
        if (!reset_n_i)
            synth_active_ff <= 1'b0;
        else if (strobe_fall && work_ff[`STCW_SE_BIT])
            synth_active_ff <= 1'b1;
        else if (gate_fall)
            synth_active_ff <= 1'b0;
    end
    assign synth_active_o = synth_active_ff;
    assign vga_enable_o   = synth_active_ff & gate_s;
endmodule

// file: design/stcw_consts.vh
`ifndef STCW_CONSTS_VH
`define STCW_CONSTS_VH
// word geometry
`define STCW_WORD_W        24
`define STCW_CNT_W         5
`define STCW_BITS_FULL     5'h18
`define STCW_CNT_ONE       5'h01
// field positions, msb first on the wire
`define STCW_ADDR_HI       23
`define STCW_ADDR_LO       21
`define STCW_ADDR_VAL      3'h1
`define STCW_ATT_HI        20
`define STCW_ATT_LO        14
`define STCW_DIV_HI        13
`define STCW_DIV_LO        12
`define STCW_MODE_BIT      11
`define STCW_SE_BIT        10
`define STCW_SM1_BIT       9
`define STCW_SM2_BIT       8
`define STCW_TAIL_HI       7
`define STCW_TAIL_LO       0
`define STCW_TAIL_VAL      8'hFF
// attenuation code layout
`define STCW_ATT_W         7
`define STCW_FINE_STEPS    7'h3C
`define STCW_COARSE_STEPS  7'h0E
`define STCW_ATT_MAX       7'h4A
// attenuation in tenths of a dB
`define STCW_ATT_DB_W      9
`define STCW_FINE_DB       9'h002
`define STCW_COARSE_DB     9'h014
`define STCW_FINE_SPAN_DB  9'h078
// divider ratios
`define STCW_RATIO_W       4
`define STCW_RATIO_BASE    4'h6
`endif

// file: design/stcw_sync.v
`timescale 1ns/10ps
module stcw_sync (
    // clock and reset
    input  wire mclk_i,
    input  wire reset_n_i,
    // async level in, synced level out
    input  wire async_i,
    output wire sync_o
);
    reg meta_ff;
    reg sync_ff;
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end
    assign sync_o = sync_ff;
endmodule

// file: dv/stcw_sva.sv
`timescale 1ns/10ps
module stcw_sva (
    // watched ports
    input wire       mclk_i,
    input wire       reset_n_i,
    input wire       strobe_i,
    input wire       transmit_gate_i,
    input wire [6:0] attenuation_code_o,
    input wire [8:0] atten_tenth_db_o,
    input wire       divide_select_high_o,
    input wire       divide_select_low_o,
    input wire [3:0] divide_ratio_o,
    input wire       offset_synth_enable_o,
    input wire       synth_active_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    property p_div; divide_ratio_o == 4'h6 + $past({divide_select_high_o, divide_select_low_o}); endproperty
    a_div: assert property (p_div) else $error("ratio wrong");
    property p_fin;
        $past(attenuation_code_o) <= 7'h3C |-> atten_tenth_db_o == 2 * $past(attenuation_code_o);
    endproperty
    a_fin: assert property (p_fin) else $error("fine step wrong");
    property p_rng; atten_tenth_db_o <= 9'h190; endproperty
    a_rng: assert property (p_rng) else $error("span exceeded");
    property p_ld; $changed({attenuation_code_o, offset_synth_enable_o}) |-> $past(strobe_i, 3); endproperty
    a_ld: assert property (p_ld) else $error("load without strobe");
    property p_set; $rose(synth_active_o) |-> offset_synth_enable_o && !strobe_i; endproperty
    a_set: assert property (p_set) else $error("bad set");
    property p_clr; $fell(transmit_gate_i) && !$fell(strobe_i) |-> ##4 !synth_active_o; endproperty
    a_clr: assert property (p_clr) else $error("no clear");
    property p_fel; $fell(synth_active_o) |-> !$past(transmit_gate_i, 2); endproperty
    a_fel: assert property (p_fel) else $error("bad clear");
    property p_ris; $rose(transmit_gate_i) && synth_active_o |-> ##4 synth_active_o; endproperty
    a_ris: assert property (p_ris) else $error("rise cleared");
endmodule
bind stcw_top stcw_sva u_sva (.mclk_i, .reset_n_i, .strobe_i, .transmit_gate_i, .attenuation_code_o,
    .atten_tenth_db_o, .divide_select_high_o, .divide_select_low_o, .divide_ratio_o,
    .offset_synth_enable_o, .synth_active_o);

// file: dv/stcw_host.sv
`timescale 1ns/10ps
module stcw_host (
    // clock
    input  wire mclk_i,
    // serial pins
    output reg  sclk_o = 1'b0,
    output reg  sdata_o = 1'b0,
    output reg  strobe_o = 1'b0
);
    // msb first, 320 ns serial period, clock idles low
    task load(input [23:0] w);
        integer i;
        begin
            for (i = 23; i >= 0; i = i - 1) begin
                sdata_o <= w[i];
                repeat (4) @(posedge mclk_i);
                sclk_o <= 1'b1;
                repeat (4) @(posedge mclk_i);
                sclk_o <= 1'b0;
            end
            sdata_o <= ~w[0];
            strobe_o <= 1'b1;
            repeat (8) @(posedge mclk_i);
            strobe_o <= 1'b0;
            repeat (8) @(posedge mclk_i);
        end
    endtask
endmodule

// file: dv/serial_transmit_control_word_tb_top.sv
`timescale 1ns/10ps
module serial_transmit_control_word_tb_top;
    reg        mclk = 1'b0;
    reg        rst_n = 1'b0;
    reg        gate = 1'b0;
    reg  [6:0] a;
    wire       sclk, sdata, stb, hi, lo, md, se, s1, s2, sa, vga;
    wire [6:0] att;
    wire [8:0] db;
    wire [3:0] ratio;
    integer    bad_count = 0;
    integer    n_compared = 0;
    integer    k;
    always #20 mclk = ~mclk;
    stcw_top DUT (.mclk_i(mclk), .reset_n_i(rst_n), .sclk_i(sclk), .sdata_i(sdata), .strobe_i(stb),
        .transmit_gate_i(gate), .attenuation_code_o(att), .atten_tenth_db_o(db), .divide_select_high_o(hi),
        .divide_select_low_o(lo), .divide_ratio_o(ratio), .driver_mode_o(md), .offset_synth_enable_o(se),
        .lo_buffer_sleep_o(s1), .refclk_buffer_sleep_o(s2), .synth_active_o(sa), .vga_enable_o(vga));
    stcw_host u_host (.mclk_i(mclk), .sclk_o(sclk), .sdata_o(sdata), .strobe_o(stb));
    task chk(input [63:0] nm, input [25:0] e, input [25:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                bad_count = bad_count + 1;
                $display("[FAIL] %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task final_report;
        begin
            $display("compared %0d mismatched %0d", n_compared, bad_count);
            if (bad_count == 0 && n_compared > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task t_fields;
        begin
            for (k = 0; k < 4; k = k + 1) begin
                a = 7'h18 * k[6:0];
                u_host.load({3'h1, a, k[1:0], k[0], k[1], ~k[0], k[0] ^ k[1], 8'hFF});
                chk("fields", {a, k[1:0], k[0], k[1], ~k[0], k[0] ^ k[1], 4'h6 + k[3:0],
                    (a > 7'h3C) ? 9'h078 + 9'h014 * (a - 7'h3C) : {1'b0, a, 1'b0}},
                    {att, hi, lo, md, se, s1, s2, ratio, db});
            end
        end
    endtask
    task t_refuse;
        begin
            u_host.load({3'h2, 7'h05, 14'h3FFF});
            u_host.load({3'h1, 7'h05, 6'h3F, 8'h7F});
            chk("kept", {7'h48, 6'h3C}, {att, hi, lo, md, se, s1, s2});
        end
    endtask
    task t_synth;
        begin
            gate <= 1'b1;
            repeat (6) @(posedge mclk);
            chk("gate_up", 2'b11, {sa, vga});
            gate <= 1'b0;
            repeat (6) @(posedge mclk);
            chk("gate_dn", 2'b00, {sa, vga});
            u_host.load({3'h1, 7'h7F, 6'h07, 8'hFF});
            chk("clamp", {1'b1, 9'h190}, {sa, db});
            gate <= 1'b1;
            repeat (6) @(posedge mclk);
            gate <= 1'b0;
            u_host.load({3'h1, 7'h00, 6'h03, 8'hFF});
            chk("off", 2'b00, {sa, se});
        end
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        t_fields;
        t_refuse;
        t_synth;
        final_report;
    end
    // eight loads of about 210 cycles each, with wide margin
    initial begin
        #400000;
        bad_count = bad_count + 1;
        final_report;
    end
endmodule
